// >>> rtl/bms_boot_ctrl.sv
// Purpose: Senses the boot straps, picks the boot flow and runs the factory restore.
// Assumes: APB slave with one wait state; all inputs synchronous to clk.
// Notes: A restore marker on the nonvolatile ports survives power loss.
//
// Contract
// - The three strap pins are caught at power-up into a register, which picks the mode.
// - The caught value picks the boot flow and maps pins to debug or the first serial port.
// - Serial load mode waits forever for code to arrive over the serial port.
// - Serial load mode also sets up the four-wire debug port.
// - Only pin 0 high boots functionally with two-wire debug on the mode and clock pins; once a restore has finished the code runs four-wire debug instead.
// - All pins low boots functionally with four-wire debug.
// - Only pin 1 high looks for a break on receive; break loads, else four-wire run.
// - The restore pattern with a reset release starts the factory restore.
// - Restore settings are none, parameters only, or image and parameters.
// - The factory image sector is refused to every host processor access.
// - A restore cut short by power loss resumes when power returns.
// - A restore lasts about eight seconds.
// - Pins 0 and 1 drive the RF switch after boot and serve nothing else.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "bms_regs.svh"

module bms_boot_ctrl #(
	parameter int unsigned RESTORE_CYCLES = `BMS_RESTORE_TIME_S * `BMS_CLK_HZ,
	parameter int unsigned BREAK_CYCLES   = `BMS_BREAK_TIME_US * (`BMS_CLK_HZ / 1000000),
	parameter int unsigned WINDOW_CYCLES  = `BMS_BRK_WINDOW_US * (`BMS_CLK_HZ / 1000000),
	parameter int unsigned HADDR_W        = 24,
	parameter logic [23:0] FACT_BASE      = 24'hf00000,
	parameter logic [23:0] FACT_LAST      = 24'hffffff
) (
	input  wire logic               clk,
	input  wire logic               rstn,
	input  wire logic               ce,
	input  wire logic [11:0]        paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic                    pready,
	output logic [31:0]             prdata,
	output logic                    pslverr,
	input  wire logic [2:0]         senseIn,
	output logic [2:0]              senseOut,
	output logic [2:0]              senseOen_n,
	input  wire logic               serialRxd,
	input  wire logic               nvPendIn,
	input  wire logic [1:0]         nvKindIn,
	output logic                    nvPendOut,
	output logic [1:0]              nvKindOut,
	input  wire logic               hostReq,
	input  wire logic [HADDR_W-1:0] hostAddr,
	output logic                    hostGrant,
	output logic                    hostDeny,
	output logic [2:0]              bootSense,
	output logic                    jtag4En,
	output logic                    swdEn,
	output logic                    serialPortEn,
	output logic                    loadActive,
	output logic                    runActive,
	output logic                    restoreBusy,
	output logic                    restoreDone
);

	bms_pkg::bms_state_t state_q;
	bms_pkg::bms_state_t state_d;

	logic [2:0]              sense_q;
	logic                    senseValid_q;
	logic                    resume_q;
	logic [1:0]              resumeKind_q;
	logic [`BMS_CTRL_W-1:0]  ctrl_q;
	logic [31:0]             restCnt_q;
	logic [1:0]              kind_q;
	logic                    done_q;
	logic                    brkStart_q;
	logic                    brkDone;
	logic                    brkFound;

	// Strap decode from the caught value only, never from the live pins.
	wire isLoad    = (sense_q == `BMS_SOP_LOAD);
	wire isTwo     = (sense_q == `BMS_SOP_TWO_WIRE);
	wire isBreak   = (sense_q == `BMS_SOP_BREAK);
	wire isRestore = (sense_q == `BMS_SOP_RESTORE);

	wire [1:0] ctrlSel  = ctrl_q[`BMS_CTRL_SEL_HI:`BMS_CTRL_SEL_LO];
	wire [1:0] ctrlRf   = ctrl_q[`BMS_CTRL_RF_HI:`BMS_CTRL_RF_LO];
	wire       selValid = (ctrlSel == `BMS_RST_PARAMS) | (ctrlSel == `BMS_RST_IMAGE);

	// APB decode: one wait state, write lands at the edge that sees pready.
	wire apbAcc   = psel & penable;
	wire apbPrep  = apbAcc & ~pready;
	wire apbFire  = apbAcc & pready;
	wire hitStat  = (paddr == `BMS_OFF_STATUS);
	wire hitCtrl  = (paddr == `BMS_OFF_CTRL);
	wire hitProg  = (paddr == `BMS_OFF_PROGRESS);
	wire unmapped = ~(hitStat | hitCtrl | hitProg);
	wire ctrlWr   = apbFire & pwrite & hitCtrl;
	wire swStart  = ctrlWr & pwdata[`BMS_CTRL_START];

	wire [31:0] statusWord;
	assign statusWord[`BMS_ST_SENSE_HI:`BMS_ST_SENSE_LO] = sense_q;
	assign statusWord[`BMS_ST_STATE_HI:`BMS_ST_STATE_LO] = state_q;
	assign statusWord[`BMS_ST_JTAG4]                     = jtag4En;
	assign statusWord[`BMS_ST_SWD]                       = swdEn;
	assign statusWord[`BMS_ST_SERIAL]                    = serialPortEn;
	assign statusWord[`BMS_ST_DONE]                      = done_q;
	assign statusWord[`BMS_ST_PEND]                      = nvPendOut;
	assign statusWord[`BMS_ST_KIND_HI:`BMS_ST_KIND_LO]   = kind_q;
	assign statusWord[31:`BMS_ST_KIND_HI+1]              = '0;

	wire [31:0] ctrlWord = {{(32-`BMS_CTRL_W){1'b0}},
		ctrl_q & ~(`BMS_CTRL_W'(1) << `BMS_CTRL_START)};

	wire [31:0] rdMux = hitStat ? statusWord :
		hitCtrl ? ctrlWord :
		hitProg ? restCnt_q : 32'h0;

	// Restore bookkeeping.
	wire restEnd   = (state_q == bms_pkg::ST_RESTORE) &&
		(restCnt_q == RESTORE_CYCLES - 1);
	wire enterRest = (state_q != bms_pkg::ST_RESTORE) &&
		(state_d == bms_pkg::ST_RESTORE);
	wire [1:0] entryKind = resume_q ? resumeKind_q : ctrlSel;

	// Host access check against the protected factory sector.
	wire [23:0] hostAddrW = 24'(hostAddr);
	wire inFactory = (hostAddrW >= FACT_BASE) && (hostAddrW <= FACT_LAST);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			bms_pkg::ST_SENSE: begin
				if (senseValid_q) begin
					if (resume_q) begin
						state_d = bms_pkg::ST_RESTORE;
					end else if (isRestore && selValid) begin
						state_d = bms_pkg::ST_RESTORE;
					end else if (isLoad) begin
						state_d = bms_pkg::ST_LOAD;
					end else if (isBreak) begin
						state_d = bms_pkg::ST_BREAK;
					end else begin
						state_d = bms_pkg::ST_RUN;
					end
				end
			end
			bms_pkg::ST_BREAK: begin
				if (brkDone) begin
					state_d = brkFound ? bms_pkg::ST_LOAD : bms_pkg::ST_RUN;
				end
			end
			bms_pkg::ST_LOAD: begin
				state_d = bms_pkg::ST_LOAD;
			end
			bms_pkg::ST_RUN: begin
				if (swStart && (pwdata[`BMS_CTRL_SEL_HI:`BMS_CTRL_SEL_LO] == `BMS_RST_PARAMS ||
						pwdata[`BMS_CTRL_SEL_HI:`BMS_CTRL_SEL_LO] == `BMS_RST_IMAGE)) begin
					state_d = bms_pkg::ST_RESTORE;
				end
			end
			bms_pkg::ST_RESTORE: begin
				if (restEnd) begin
					state_d = bms_pkg::ST_RUN;
				end
			end
			default: begin
				state_d = bms_pkg::ST_SENSE;
			end
		endcase
	end

	// Pin mapping follows the next state so the outputs stay registered.
	wire nxtRun   = (state_d == bms_pkg::ST_RUN);
	wire nxtLoad  = (state_d == bms_pkg::ST_LOAD);
	wire nxtBrk   = (state_d == bms_pkg::ST_BREAK);
	wire nxtRest  = (state_d == bms_pkg::ST_RESTORE);
	wire nxtBoot  = (state_d != bms_pkg::ST_SENSE);
	wire nxtSwd   = nxtRun & isTwo & ~done_q & ~restEnd;
	wire nxtJtag4 = nxtLoad | nxtBrk | (nxtRun & ~nxtSwd) | nxtRest;
	wire nxtSer   = nxtLoad | nxtBrk;

	wire [2:0] nxtOut = {ctrl_q[`BMS_CTRL_P2_VAL], ctrlRf};
	wire [2:0] nxtOen = nxtBoot ? {~ctrl_q[`BMS_CTRL_P2_OE], 2'b00} : 3'b111;

	// Strap capture: first enabled edge after reset release, then frozen.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			senseValid_q <= 1'b0;
			sense_q      <= 3'h0;
			resume_q     <= 1'b0;
			resumeKind_q <= 2'h0;
		end else if (ce && !senseValid_q) begin
			senseValid_q <= 1'b1;
			sense_q      <= senseIn;
			resume_q     <= nvPendIn &&
				(nvKindIn == `BMS_RST_PARAMS || nvKindIn == `BMS_RST_IMAGE);
			resumeKind_q <= nvKindIn;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q    <= bms_pkg::ST_SENSE;
			brkStart_q <= 1'b0;
		end else if (ce) begin
			state_q    <= state_d;
			brkStart_q <= (state_q == bms_pkg::ST_SENSE) && (state_d == bms_pkg::ST_BREAK);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl_q <= `BMS_CTRL_RST;
		end else if (ce && ctrlWr) begin
			ctrl_q <= pwdata[`BMS_CTRL_W-1:0] & ~(`BMS_CTRL_W'(1) << `BMS_CTRL_START);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			restCnt_q <= 32'h0;
			kind_q    <= `BMS_RST_NONE;
			done_q    <= 1'b0;
			nvPendOut <= 1'b0;
			nvKindOut <= `BMS_RST_NONE;
		end else if (ce) begin
			if (enterRest) begin
				restCnt_q <= 32'h0;
				kind_q    <= swStart ? pwdata[`BMS_CTRL_SEL_HI:`BMS_CTRL_SEL_LO] : entryKind;
				nvPendOut <= 1'b1;
				nvKindOut <= swStart ? pwdata[`BMS_CTRL_SEL_HI:`BMS_CTRL_SEL_LO] : entryKind;
				done_q    <= 1'b0;
			end else if (restEnd) begin
				nvPendOut <= 1'b0;
				done_q    <= 1'b1;
			end else if (state_q == bms_pkg::ST_RESTORE) begin
				restCnt_q <= restCnt_q + 32'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			bootSense    <= 3'h0;
			jtag4En      <= 1'b0;
			swdEn        <= 1'b0;
			serialPortEn <= 1'b0;
			loadActive   <= 1'b0;
			runActive    <= 1'b0;
			restoreBusy  <= 1'b0;
			restoreDone  <= 1'b0;
		end else if (ce) begin
			bootSense    <= senseValid_q ? sense_q : senseIn;
			jtag4En      <= nxtJtag4;
			swdEn        <= nxtSwd;
			serialPortEn <= nxtSer;
			loadActive   <= nxtLoad;
			runActive    <= nxtRun;
			restoreBusy  <= nxtRest;
			restoreDone  <= restEnd | (done_q & ~enterRest);
		end
	end

	// After boot, pins 0 and 1 only ever drive the RF switch.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			senseOut   <= 3'h0;
			senseOen_n <= 3'h7;
		end else if (ce) begin
			senseOut   <= nxtOut;
			senseOen_n <= nxtOen;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			hostGrant <= 1'b0;
			hostDeny  <= 1'b0;
		end else if (ce) begin
			hostGrant <= hostReq & ~inFactory;
			hostDeny  <= hostReq & inFactory;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready  <= apbPrep;
			prdata  <= apbPrep ? rdMux : 32'h0;
			pslverr <= apbPrep & unmapped;
		end
	end

	bms_break_detect #(
		.BREAK_CYCLES  (BREAK_CYCLES),
		.WINDOW_CYCLES (WINDOW_CYCLES)
	) uBreak (
		.clk   (clk),
		.rstn  (rstn),
		.ce    (ce),
		.start (brkStart_q),
		.rxd   (serialRxd),
		.done  (brkDone),
		.found (brkFound)
	);

endmodule : bms_boot_ctrl

// >>> rtl/bms_break_detect.sv
// Purpose: Watches the serial receive line for a break after a start pulse.
// Assumes: The line idles high; a break holds it low for BREAK_CYCLES.
// Notes: Gives up after WINDOW_CYCLES with found low.
`timescale 1ns/1ps

module bms_break_detect #(
	parameter int unsigned BREAK_CYCLES  = 10000,
	parameter int unsigned WINDOW_CYCLES = 100000
) (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic ce,
	input  wire logic start,
	input  wire logic rxd,
	output logic      done,
	output logic      found
);

	logic        busy_q;
	logic [31:0] lowCnt_q;
	logic [31:0] winCnt_q;

	wire hit     = busy_q & ~rxd & (lowCnt_q == BREAK_CYCLES - 1);
	wire timeout = busy_q & (winCnt_q == WINDOW_CYCLES - 1);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			busy_q   <= 1'b0;
			lowCnt_q <= 32'h0;
			winCnt_q <= 32'h0;
			done     <= 1'b0;
			found    <= 1'b0;
		end else if (ce) begin
			busy_q   <= (busy_q | start) & ~hit & ~timeout;
			lowCnt_q <= (busy_q & ~rxd) ? lowCnt_q + 32'h1 : 32'h0;
			winCnt_q <= busy_q ? winCnt_q + 32'h1 : 32'h0;
			done     <= hit | timeout;
			found    <= hit;
		end
	end

endmodule : bms_break_detect

// >>> rtl/bms_pkg.sv
// Purpose: Types shared by the boot sense block.
// Assumes: Nothing beyond the register header.
// Notes: Boot states are binary coded.
package bms_pkg;

	typedef enum logic [2:0] {
		ST_SENSE   = 3'h0,
		ST_BREAK   = 3'h1,
		ST_LOAD    = 3'h2,
		ST_RUN     = 3'h3,
		ST_RESTORE = 3'h4
	} bms_state_t;

endpackage : bms_pkg

// >>> rtl/bms_regs.svh
// Purpose: Offsets, field positions, reset values and timing figures of the boot sense block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Definitions only.
`ifndef BMS_REGS_SVH
`define BMS_REGS_SVH

`define BMS_OFF_STATUS     12'h000
`define BMS_OFF_CTRL       12'h004
`define BMS_OFF_PROGRESS   12'h008

`define BMS_SOP_LOAD       3'h4
`define BMS_SOP_TWO_WIRE   3'h1
`define BMS_SOP_FOUR_WIRE  3'h0
`define BMS_SOP_BREAK      3'h2
`define BMS_SOP_RESTORE    3'h6

`define BMS_RST_NONE       2'h0
`define BMS_RST_PARAMS     2'h1
`define BMS_RST_IMAGE      2'h2

`define BMS_CTRL_SEL_LO    0
`define BMS_CTRL_SEL_HI    1
`define BMS_CTRL_START     2
`define BMS_CTRL_RF_LO     3
`define BMS_CTRL_RF_HI     4
`define BMS_CTRL_P2_VAL    5
`define BMS_CTRL_P2_OE     6
`define BMS_CTRL_W         7
`define BMS_CTRL_RST       7'h02

`define BMS_ST_SENSE_LO    0
`define BMS_ST_SENSE_HI    2
`define BMS_ST_STATE_LO    3
`define BMS_ST_STATE_HI    5
`define BMS_ST_JTAG4       6
`define BMS_ST_SWD         7
`define BMS_ST_SERIAL      8
`define BMS_ST_DONE        9
`define BMS_ST_PEND        10
`define BMS_ST_KIND_LO     11
`define BMS_ST_KIND_HI     12

`define BMS_CLK_HZ         100000000
`define BMS_RESTORE_TIME_S 8
`define BMS_BREAK_TIME_US  100
`define BMS_BRK_WINDOW_US  1000

`endif

// >>> tb/bms_board_model.sv
// Purpose: Strap resistors and serial loader line seen by the boot sense block.
// Assumes: Every strap pin has a pull resistor; the receive line has a pull-up.
// Notes: Purely combinational.
`timescale 1ns/1ps

module bms_board_model (
	input wire logic [2:0] strap,
	input wire logic       breakOn,
	input wire logic [2:0] senseOut,
	input wire logic [2:0] senseOen_n,
	output logic     [2:0] senseIn,
	output logic           serialRxd
);
	// A released pin falls back to its resistor level, a driven one follows the device.
	assign senseIn   = (senseOen_n & strap) | (~senseOen_n & senseOut);
	// The loader holds the line low for a break, otherwise the pull-up wins.
	assign serialRxd = !breakOn;
endmodule : bms_board_model

// >>> tb/bms_boot_ctrl_assertions.sv
// Purpose: Concurrent checks on the ports of the boot sense block.
// Assumes: The clock enable is held high by the bench.
// Notes: Bound into every instance of the block.
`timescale 1ns/1ps

module bms_boot_ctrl_chk #(
	parameter int unsigned RESTORE_CYCLES = 50,
	parameter int unsigned HADDR_W        = 24,
	parameter logic [23:0] FACT_BASE      = 24'hf00000,
	parameter logic [23:0] FACT_LAST      = 24'hffffff
) (
	input wire logic               clk,
	input wire logic               rstn,
	input wire logic               hostReq,
	input wire logic [HADDR_W-1:0] hostAddr,
	input wire logic               hostGrant,
	input wire logic               hostDeny,
	input wire logic [2:0]         bootSense,
	input wire logic [2:0]         senseOen_n,
	input wire logic               jtag4En,
	input wire logic               swdEn,
	input wire logic               loadActive,
	input wire logic               runActive,
	input wire logic               restoreBusy,
	input wire logic               restoreDone,
	input wire logic               nvPendOut
);
	logic [31:0] busyCnt_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// Counts the cycles of one restore so its length can be judged at the end.
	always_ff @(posedge clk) begin
		if (!rstn)
			busyCnt_q <= 32'h0;
		else
			busyCnt_q <= restoreBusy ? busyCnt_q + 32'h1 : 32'h0;
	end

	host_deny_a: assert property (hostReq && hostAddr >= FACT_BASE && hostAddr <= FACT_LAST
		|=> hostDeny && !hostGrant) else $error("protected sector access not denied");
	host_grant_a: assert property (hostReq && (hostAddr < FACT_BASE || hostAddr > FACT_LAST)
		|=> hostGrant && !hostDeny) else $error("open flash access not granted");
	sense_hold_a: assert property ((runActive && $past(runActive))
		|| (loadActive && $past(loadActive)) |-> $stable(bootSense)) else $error("caught straps moved");
	load_jtag_a: assert property (loadActive |-> jtag4En && !swdEn && !runActive)
		else $error("load mode without four-wire debug");
	swd_run_a: assert property (swdEn |-> runActive && !jtag4En)
		else $error("two-wire debug outside run");
	busy_pend_a: assert property (restoreBusy |-> nvPendOut && !runActive)
		else $error("restore marker not kept during restore");
	restore_len_a: assert property ($fell(restoreBusy) |-> busyCnt_q >= RESTORE_CYCLES - 2
		&& busyCnt_q <= RESTORE_CYCLES + 2) else $error("restore length wrong");
	restore_end_a: assert property ($fell(restoreBusy) |-> restoreDone && runActive
		&& jtag4En && !nvPendOut) else $error("restore end state wrong");
	rf_drive_a: assert property (runActive |-> senseOen_n[1:0] == 2'b00)
		else $error("switch pins not driven in run");
endmodule : bms_boot_ctrl_chk

bind bms_boot_ctrl bms_boot_ctrl_chk #(.RESTORE_CYCLES(RESTORE_CYCLES), .HADDR_W(HADDR_W),
	.FACT_BASE(FACT_BASE), .FACT_LAST(FACT_LAST)) chk (.clk(clk), .rstn(rstn), .hostReq(hostReq),
	.hostAddr(hostAddr), .hostGrant(hostGrant), .hostDeny(hostDeny), .bootSense(bootSense),
	.senseOen_n(senseOen_n), .jtag4En(jtag4En), .swdEn(swdEn), .loadActive(loadActive),
	.runActive(runActive), .restoreBusy(restoreBusy), .restoreDone(restoreDone),
	.nvPendOut(nvPendOut));

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the boot sense block.
// Assumes: Shortened restore, break and window counts.
// Notes: Register reads are checked from a queue by a monitor.
`timescale 1ns/1ps
`include "bms_regs.svh"

module tb_top;
	logic        clk, rstn, psel, penable, pwrite, pready, pslverr, breakOn, nvPendIn;
	logic        hostReq, hostGrant, hostDeny, serialRxd, nvPendOut, jtag4En, swdEn;
	logic        serialPortEn, loadActive, runActive, restoreBusy, restoreDone;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rnd, d;
	logic [2:0]  senseIn, senseOut, senseOen_n, bootSense, strap;
	logic [1:0]  nvKindIn, nvKindOut;
	logic [23:0] hostAddr;
	logic [32:0] expQ[$];
	logic [2:0]  pat [5] = '{`BMS_SOP_LOAD, `BMS_SOP_TWO_WIRE, `BMS_SOP_FOUR_WIRE,
		`BMS_SOP_BREAK, `BMS_SOP_BREAK};
	logic [3:0]  modeExp [5] = '{4'ha, 4'h5, 4'h6, 4'h6, 4'ha};
	int          errors, total_checks;

	bms_boot_ctrl #(.RESTORE_CYCLES(50), .BREAK_CYCLES(4), .WINDOW_CYCLES(40)) uut (
		.clk(clk), .rstn(rstn), .ce(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.senseIn(senseIn), .senseOut(senseOut), .senseOen_n(senseOen_n), .serialRxd(serialRxd),
		.nvPendIn(nvPendIn), .nvKindIn(nvKindIn), .nvPendOut(nvPendOut), .nvKindOut(nvKindOut),
		.hostReq(hostReq), .hostAddr(hostAddr), .hostGrant(hostGrant), .hostDeny(hostDeny),
		.bootSense(bootSense), .jtag4En(jtag4En), .swdEn(swdEn), .serialPortEn(serialPortEn),
		.loadActive(loadActive), .runActive(runActive), .restoreBusy(restoreBusy),
		.restoreDone(restoreDone));

	bms_board_model board (.strap(strap), .breakOn(breakOn), .senseOut(senseOut),
		.senseOen_n(senseOen_n), .senseIn(senseIn), .serialRxd(serialRxd));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction : xs

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic results;
		$display("errors=%0d total_checks=%0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		input logic [32:0] e);
		int n;
		n = 0;
		expQ.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			errors++;
			results;
		end
		// One idle edge keeps a following call from driving psel twice in one step.
		@(posedge clk);
	endtask : apb

	task automatic boot(input logic [2:0] p, input logic b, input logic np, input logic [1:0] nk);
		rstn <= 1'b0;
		strap <= p;
		breakOn <= b;
		nvPendIn <= np;
		nvKindIn <= nk;
		hostReq <= 1'b0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		nvPendIn <= 1'b0;
	endtask : boot

	task automatic waitDone;
		int n;
		for (n = 0; n < 200 && restoreDone !== 1'b1; n++)
			@(posedge clk);
		if (n >= 200) begin
			errors++;
			results;
		end
	endtask : waitDone

	// Each completed transfer is judged against the oldest expectation.
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1) begin
			if (expQ.size() == 0)
				chk(33'h1ffffffff, 33'h0);
			else
				chk({pslverr, prdata}, expQ.pop_front());
		end
	end

	initial begin
		{rstn, psel, penable, pwrite, hostReq, breakOn, nvPendIn} = 7'h0;
		{paddr, pwdata, strap, nvKindIn, hostAddr} = '0;
		errors = 0;
		total_checks = 0;
		rnd = 32'h39b2ca53;
		@(posedge clk);
		for (int i = 0; i < 5; i++) begin
			boot(pat[i], i == 4, 1'b0, 2'h0);
			repeat (60) @(posedge clk);
			chk({loadActive, runActive, jtag4En, swdEn}, modeExp[i]);
			chk(bootSense, pat[i]);
			chk(serialPortEn, modeExp[i][3]);
			strap <= ~pat[i];
			repeat (5) @(posedge clk);
			chk(bootSense, pat[i]);
		end
		boot(`BMS_SOP_FOUR_WIRE, 1'b0, 1'b0, 2'h0);
		apb(1'b0, `BMS_OFF_CTRL, 32'h0, {1'b0, 32'h2});
		apb(1'b0, `BMS_OFF_STATUS, 32'h0, {1'b0, 32'h58});
		apb(1'b0, 12'h00c, 32'h0, {1'b1, 32'h0});
		rnd = xs(rnd);
		d = rnd & 32'h78;
		// A write shows the register's old contents on prdata while pready is high.
		apb(1'b1, `BMS_OFF_CTRL, d, {1'b0, 32'h2});
		apb(1'b0, `BMS_OFF_CTRL, 32'h0, {1'b0, d});
		chk({senseOut, senseOen_n}, {d[5:3], ~d[6], 2'b00});
		for (int i = 0; i < 8; i++) begin
			rnd = xs(rnd);
			hostAddr <= {(i % 2 == 1) ? 4'hf : rnd[23:20], rnd[19:0]};
			hostReq <= 1'b1;
			repeat (2) @(posedge clk);
			chk({hostGrant, hostDeny}, {hostAddr < 24'hf00000, hostAddr >= 24'hf00000});
		end
		boot(`BMS_SOP_RESTORE, 1'b0, 1'b0, 2'h0);
		chk({restoreBusy, nvPendOut, nvKindOut}, {2'b11, `BMS_RST_IMAGE});
		waitDone;
		chk({restoreBusy, runActive, jtag4En, nvPendOut}, 4'b0110);
		apb(1'b1, `BMS_OFF_CTRL, 32'h4 | `BMS_RST_NONE, {1'b0, 32'h2});
		repeat (3) @(posedge clk);
		chk(restoreBusy, 1'b0);
		apb(1'b1, `BMS_OFF_CTRL, 32'h4 | `BMS_RST_PARAMS, 33'h0);
		repeat (2) @(posedge clk);
		chk({restoreBusy, nvKindOut}, {1'b1, `BMS_RST_PARAMS});
		waitDone;
		boot(`BMS_SOP_FOUR_WIRE, 1'b0, 1'b1, `BMS_RST_PARAMS);
		chk({restoreBusy, nvKindOut}, {1'b1, `BMS_RST_PARAMS});
		waitDone;
		chk({runActive, restoreDone}, 2'b11);
		results;
	end
endmodule : tb_top
